/* bench/fsg_props.sv */
// Concurrent checks on the ports of the flash sector write guard.
`timescale 1ns/1ns
module fsg_props
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic write_guard_option,
  input wire logic op_req,
  input wire logic op_grant,
  input wire logic op_block,
  input wire logic [7:0] sector_lock_bit,
  input wire logic [15:0] program_timing_value,
  input wire logic [7:0] page_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_wrote(logic [13:0] a);
    $past(wr_done) && $past(paddr) == a;
  endsequence
  a_ready_wait: assert property (s_access |=> pready) else $error("pready late");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_lock_sticky: assert property (!$past(srst) |-> ($past(sector_lock_bit) & ~sector_lock_bit) == 8'h00)
    else $error("lock bit cleared");
  a_lock_cause: assert property (!$past(srst) && !$stable(sector_lock_bit) |-> s_wrote(14'h3fe4))
    else $error("lock changed without write");
  a_page_cause: assert property (!$past(srst) && !$stable(page_select) |->
    s_wrote(14'h3fe4) or s_wrote(14'h3ff0)) else $error("page changed without write");
  a_timing_cause: assert property (!$past(srst) && !$stable(program_timing_value) |->
    s_wrote(14'h3fe8) or s_wrote(14'h3fec)) else $error("timing changed without write");
  a_op_answer: assert property (op_req |=> op_grant ^ op_block) else $error("no op answer");
  a_op_cause: assert property (op_grant || op_block |-> $past(op_req)) else $error("stray op answer");
  a_guard_block: assert property (op_req && write_guard_option && $past(write_guard_option) |=>
    op_block) else $error("guard did not block");
endmodule
bind fsg_top fsg_props i_props (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .write_guard_option(write_guard_option), .op_req(op_req), .op_grant(op_grant),
  .op_block(op_block), .sector_lock_bit(sector_lock_bit),
  .program_timing_value(program_timing_value), .page_select(page_select));

/* bench/tb_top.sv */
// Self-checking bench for the flash sector write guard.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, op_grant, op_block;
  logic [1:0] variant = 2'h0;
  logic read_guard_option = 1'b0;
  logic write_guard_option = 1'b0;
  logic op_req = 1'b0;
  logic [12:0] op_addr = 13'h0;
  logic [7:0] sector_lock_bit, page_select, th, tl;
  logic [15:0] program_timing_value;
  logic [1:0] prot_level;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [1:0] op_q[$];
  logic [1:0] o;
  int n_fail = 0;
  int samples_checked = 0;
  integer seed = 32'h41c99f24;
  always #50 clk = ~clk;
  fsg_top i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .variant(variant), .read_guard_option(read_guard_option),
    .write_guard_option(write_guard_option), .op_req(op_req), .op_addr(op_addr),
    .op_grant(op_grant), .op_block(op_block), .sector_lock_bit(sector_lock_bit),
    .program_timing_value(program_timing_value), .page_select(page_select),
    .prot_level(prot_level));
  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // --------------------------------------------------------------
  // Bus master: the request stands until pready is seen high at a rising edge.
  // --------------------------------------------------------------
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
    input logic [33:0] x);
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 34'h0);
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] x);
    xfer(1'b0, a, 32'h0, {2'b10, 24'h0, x});
  endtask
  task automatic lock(input logic [7:0] d);
    wr(14'h3fe0, 8'h5e);
    wr(14'h3fe4, d);
  endtask
  task automatic op(input logic [12:0] a, input logic b);
    op_q.push_back({b, !b});
    op_req <= 1'b1;
    op_addr <= a;
    @(posedge clk);
    op_req <= 1'b0;
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33])
        check("prdata", e[31:0], prdata);
    end
  // The answer to a one-cycle request stands for exactly one cycle.
  always @(posedge clk)
    if (op_grant === 1'b1 || op_block === 1'b1)
    begin
      o = op_q.pop_front();
      check("op_block", {31'h0, o[1]}, {31'h0, op_block});
      check("op_grant", {31'h0, o[0]}, {31'h0, op_grant});
    end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    th = 8'($random(seed));
    tl = 8'($random(seed));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(14'h3fe4, 8'h00);
    wr(14'h3fe4, 8'ha5);
    check("page", 32'ha5, {24'h0, page_select});
    wr(14'h3fe0, 8'h5e);
    wr(14'h3fe8, 8'h00);
    wr(14'h3fe4, 8'h01);
    check("page", 32'h01, {24'h0, page_select});
    wr(14'h3ff0, 8'h5a);
    check("page", 32'h5a, {24'h0, page_select});
    // A write with lane 0 disabled must leave the register alone.
    pstrb <= 4'h0;
    wr(14'h3ff0, 8'h3c);
    pstrb <= 4'hf;
    check("page", 32'h5a, {24'h0, page_select});
    lock(8'h05);
    check("lock", 32'h05, {24'h0, sector_lock_bit});
    lock(8'h00);
    lock(8'h80);
    rd(14'h3fe4, 8'h85);
    variant <= 2'h3;
    lock(8'hf3);
    variant <= 2'h0;
    rd(14'h3fe4, 8'h87);
    rd(14'h3ff8, 8'hff);
    variant <= 2'h2;
    rd(14'h3ff8, 8'h0f);
    variant <= 2'h3;
    rd(14'h3ff8, 8'h03);
    wr(14'h3fe8, th);
    wr(14'h3fec, tl);
    check("timing", {16'h0, th, tl}, {16'h0, program_timing_value});
    // The 10 MHz bench clock in kilohertz is 10000, loaded before any operation.
    wr(14'h3fe8, 8'h27);
    wr(14'h3fec, 8'h10);
    check("timing", 32'h2710, {16'h0, program_timing_value});
    xfer(1'b0, 14'h0, 32'h0, {2'b01, 32'h0});
    variant <= 2'h0;
    op(13'h0000, 1'b1);
    op(13'h0c00, 1'b0);
    op(13'h1c00, 1'b1);
    variant <= 2'h1;
    op(13'h0200, 1'b1);
    op(13'h0600, 1'b0);
    op(13'h1000, 1'b0);
    write_guard_option <= 1'b1;
    read_guard_option <= 1'b1;
    op(13'h0600, 1'b1);
    rd(14'h3ff4, 8'h03);
    check("prot", 32'h3, {30'h0, prot_level});
    check("bus_left", 32'h0, exp_q.size());
    check("op_left", 32'h0, op_q.size());
    print_verdict();
  end
endmodule

/* logic/fsg_pkg.sv */
// Package with register map, field layout, reset values and sizes for the flash sector write guard.
package fsg_pkg;
  // Register word indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_SECTOR_LOCK = 12'hff9;
  localparam logic [11:0] IDX_FLASH_CTRL = 12'hff8;
  localparam logic [11:0] IDX_TIMING_HIGH = 12'hffa;
  localparam logic [11:0] IDX_TIMING_LOW = 12'hffb;
  localparam logic [11:0] IDX_PAGE_SELECT = 12'hffc;
  localparam logic [11:0] IDX_GUARD_STATUS = 12'hffd;
  localparam logic [11:0] IDX_OPTION_BITS = 12'hffe;
  localparam int ADDR_W = 14;
  localparam logic [7:0] UNLOCK_CODE = 8'h5e;
  localparam int SECTORS = 8;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] VARIANT_8K = 2'h0;
  localparam logic [1:0] VARIANT_4K = 2'h1;
  localparam logic [1:0] VARIANT_2K = 2'h2;
  localparam logic [1:0] VARIANT_1K = 2'h3;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_2K = 8'h0f;
  localparam logic [7:0] MASK_1K = 8'h03;
  localparam int SHIFT_1K_SECTOR = 10;
  localparam int SHIFT_512_SECTOR = 9;
  localparam int FLASH_ADDR_W = 13;
  typedef enum logic [1:0]
  {
    FSG_PROT_NONE = 2'b00,
    FSG_PROT_WRITE = 2'b01,
    FSG_PROT_READ = 2'b10,
    FSG_PROT_FULL = 2'b11
  } fsg_prot_e;
endpackage

/* logic/fsg_sector_map.sv */
// Maps a flash byte address to its sector number and lock state for the selected variant.
`timescale 1ns/1ns
module fsg_sector_map
(
  input wire logic [1:0] variant,
  input wire logic [fsg_pkg::FLASH_ADDR_W-1:0] addr,
  input wire logic [7:0] lock,
  output logic [7:0] used_mask,
  output logic locked
);
  logic [fsg_pkg::FLASH_ADDR_W-1:0] sector_num;

  always_comb
  begin
    used_mask = fsg_pkg::MASK_ALL;
    sector_num = addr >> fsg_pkg::SHIFT_512_SECTOR;
    unique case (variant)
      fsg_pkg::VARIANT_8K:
      begin
        sector_num = addr >> fsg_pkg::SHIFT_1K_SECTOR;
      end
      fsg_pkg::VARIANT_4K:
      begin
        used_mask = fsg_pkg::MASK_ALL;
      end
      fsg_pkg::VARIANT_2K:
      begin
        used_mask = fsg_pkg::MASK_2K;
      end
      fsg_pkg::VARIANT_1K:
      begin
        used_mask = fsg_pkg::MASK_1K;
      end
    endcase
    // Addresses past the last sector fall outside the array and are never locked.
    locked = (sector_num < fsg_pkg::FLASH_ADDR_W'(fsg_pkg::SECTORS))
      && lock[sector_num[2:0]];
  end
endmodule

/* logic/fsg_top.sv */
// Flash sector write guard: APB registers, sticky sector locks, timing value and op gating.
// Behaviour
// - Shared address goes to lock register only right after control write of 5EH.
// - Lock register and page select share one address, index FF9H.
// - Lock register has eight bits, bit n guards sector n.
// - All lock bits clear at reset, all sectors unprotected.
// - Lock bits can only be set by software, never cleared until reset.
// - Sectors are 1024 bytes on 8 KB parts, 512 bytes otherwise.
// - Upper 4 bits unused on 2 KB part, upper 6 on 1 KB part.
// - Timing value is high byte in bits 15:8, low byte in bits 7:0.
// - Read and write guard option bits give four protection levels.
`timescale 1ns/1ns
module fsg_top
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] variant,
  input wire logic read_guard_option,
  input wire logic write_guard_option,
  input wire logic op_req,
  input wire logic [fsg_pkg::FLASH_ADDR_W-1:0] op_addr,
  output logic op_grant,
  output logic op_block,
  output logic [7:0] sector_lock_bit,
  output logic [15:0] program_timing_value,
  output logic [7:0] page_select,
  output logic [1:0] prot_level
);
  logic [7:0] sector_lock_register_reg;
  logic [7:0] sector_lock_register_next;
  logic [7:0] timing_high_reg;
  logic [7:0] timing_high_next;
  logic [7:0] timing_low_reg;
  logic [7:0] timing_low_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic op_grant_next;
  logic op_block_next;
  logic [1:0] prot_next;
  logic [11:0] word_idx;
  logic access;
  logic wr_ok;
  logic hit;
  logic wr_any;
  logic wr_ctrl;
  logic wr_shared;
  logic to_lock;
  logic [7:0] used_mask;
  logic op_locked;

  // Byte lane 0 carries every register; other lanes are ignored.
  assign word_idx = paddr[fsg_pkg::ADDR_W-1:2];
  assign access = psel && penable && !pready;
  assign hit = (word_idx == fsg_pkg::IDX_SECTOR_LOCK) || (word_idx == fsg_pkg::IDX_FLASH_CTRL)
    || (word_idx == fsg_pkg::IDX_TIMING_HIGH) || (word_idx == fsg_pkg::IDX_TIMING_LOW)
    || (word_idx == fsg_pkg::IDX_PAGE_SELECT) || (word_idx == fsg_pkg::IDX_GUARD_STATUS)
    || (word_idx == fsg_pkg::IDX_OPTION_BITS);
  // A write lands at the edge where the master sees pready, never one cycle before it.
  assign wr_ok = psel && penable && pready && pwrite && hit && pstrb[0];
  assign wr_any = wr_ok;
  assign wr_ctrl = wr_ok && (word_idx == fsg_pkg::IDX_FLASH_CTRL);
  assign wr_shared = wr_ok && (word_idx == fsg_pkg::IDX_SECTOR_LOCK);

  fsg_unlock_seq u_seq
  (
    .clk(clk),
    .srst(srst),
    .wr_any(wr_any),
    .wr_ctrl(wr_ctrl),
    .wr_shared(wr_shared),
    .wdata(pwdata[7:0]),
    .unlocked(to_lock)
  );

  fsg_sector_map u_map
  (
    .variant(variant),
    .addr(op_addr),
    .lock(sector_lock_register_reg),
    .used_mask(used_mask),
    .locked(op_locked)
  );

  always_comb
  begin
    sector_lock_register_next = sector_lock_register_reg;
    timing_high_next = timing_high_reg;
    timing_low_next = timing_low_reg;
    ctrl_next = ctrl_reg;
    page_next = page_reg;
    if (wr_shared && to_lock)
    begin
      // OR-in only: a written zero never clears a set bit.
      sector_lock_register_next = sector_lock_register_reg | (pwdata[7:0] & used_mask);
    end
    else if (wr_shared)
    begin
      page_next = pwdata[7:0];
    end
    if (wr_ctrl)
    begin
      ctrl_next = pwdata[7:0];
    end
    if (wr_ok && (word_idx == fsg_pkg::IDX_TIMING_HIGH))
    begin
      timing_high_next = pwdata[7:0];
    end
    if (wr_ok && (word_idx == fsg_pkg::IDX_TIMING_LOW))
    begin
      timing_low_next = pwdata[7:0];
    end
    if (wr_ok && (word_idx == fsg_pkg::IDX_PAGE_SELECT))
    begin
      page_next = pwdata[7:0];
    end
  end

  // Read mux; the shared index reads back the lock register.
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    pready_next = access;
    pslverr_next = access && !hit;
    if (access && !pwrite)
    begin
      unique case (word_idx)
        fsg_pkg::IDX_SECTOR_LOCK: prdata_next[7:0] = sector_lock_register_reg;
        fsg_pkg::IDX_FLASH_CTRL: prdata_next[7:0] = ctrl_reg;
        fsg_pkg::IDX_TIMING_HIGH: prdata_next[7:0] = timing_high_reg;
        fsg_pkg::IDX_TIMING_LOW: prdata_next[7:0] = timing_low_reg;
        fsg_pkg::IDX_PAGE_SELECT: prdata_next[7:0] = page_reg;
        fsg_pkg::IDX_GUARD_STATUS: prdata_next[1:0] = prot_level;
        fsg_pkg::IDX_OPTION_BITS: prdata_next[7:0] = used_mask;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Each option sets its own level bit; both options together give the full level, read plus write lock.
  always_comb
  begin
    prot_next = {read_guard_option, write_guard_option};
    op_grant_next = 1'b0;
    op_block_next = 1'b0;
    if (op_req)
    begin
      // Write guard forbids every program or erase; else the sector lock decides.
      op_block_next = op_locked || write_guard_option;
      op_grant_next = !(op_locked || write_guard_option);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sector_lock_register_reg <= fsg_pkg::LOCK_RESET;
      timing_high_reg <= fsg_pkg::BYTE_RESET;
      timing_low_reg <= fsg_pkg::BYTE_RESET;
      ctrl_reg <= fsg_pkg::BYTE_RESET;
      page_reg <= fsg_pkg::BYTE_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      op_grant <= 1'b0;
      op_block <= 1'b0;
      prot_level <= 2'h0;
      sector_lock_bit <= fsg_pkg::LOCK_RESET;
      program_timing_value <= 16'h0000;
      page_select <= fsg_pkg::BYTE_RESET;
    end
    else
    begin
      sector_lock_register_reg <= sector_lock_register_next;
      timing_high_reg <= timing_high_next;
      timing_low_reg <= timing_low_next;
      ctrl_reg <= ctrl_next;
      page_reg <= page_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      op_grant <= op_grant_next;
      op_block <= op_block_next;
      prot_level <= prot_next;
      sector_lock_bit <= sector_lock_register_next;
      program_timing_value <= {timing_high_next, timing_low_next};
      page_select <= page_next;
    end
  end
endmodule

/* logic/fsg_unlock_seq.sv */
// Unlock sequencer that steers the shared address write to the lock or page register.
`timescale 1ns/1ns
module fsg_unlock_seq
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_any,
  input wire logic wr_ctrl,
  input wire logic wr_shared,
  input wire logic [7:0] wdata,
  output logic unlocked
);
  logic armed_reg;
  logic armed_next;

  // Any other register write with lane 0 enabled between the code and the shared write cancels the arming.
  always_comb
  begin
    armed_next = armed_reg;
    if (wr_any)
    begin
      armed_next = wr_ctrl && (wdata == fsg_pkg::UNLOCK_CODE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      armed_reg <= 1'b0;
    end
    else
    begin
      armed_reg <= armed_next;
    end
  end

  assign unlocked = armed_reg && wr_shared;
endmodule
